//--- verilog/wake_regs_pkg.sv
// constants for the wake event status register bank
package wake_regs_pkg;

  // ****************************************
  // register indices and byte addresses
  // ****************************************
  localparam logic [7:0] IDX_STS_B = 8'h08;
  localparam logic [7:0] IDX_STS_A = 8'h09;
  localparam logic [7:0] IDX_STS_P = 8'h0A;
  localparam logic [7:0] IDX_RSVD = 8'h0B;
  localparam logic [7:0] IDX_EN_B = 8'h0C;
  localparam logic [7:0] IDX_EN_A = 8'h0D;
  localparam logic [7:0] IDX_EN_P = 8'h0E;
  localparam logic [7:0] IDX_CTRL = 8'h10;
  localparam logic [7:0] IDX_IRQ_STS = 8'h11;
  localparam logic [7:0] IDX_IRQ_EN = 8'h12;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h13;
  localparam logic [7:0] ADDR_STS_B = {IDX_STS_B[5:0], 2'b00};
  localparam logic [7:0] ADDR_STS_A = {IDX_STS_A[5:0], 2'b00};
  localparam logic [7:0] ADDR_STS_P = {IDX_STS_P[5:0], 2'b00};
  localparam logic [7:0] ADDR_RSVD = {IDX_RSVD[5:0], 2'b00};
  localparam logic [7:0] ADDR_EN_B = {IDX_EN_B[5:0], 2'b00};
  localparam logic [7:0] ADDR_EN_A = {IDX_EN_A[5:0], 2'b00};
  localparam logic [7:0] ADDR_EN_P = {IDX_EN_P[5:0], 2'b00};
  localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] ADDR_IRQ_STS = {IDX_IRQ_STS[5:0], 2'b00};
  localparam logic [7:0] ADDR_IRQ_EN = {IDX_IRQ_EN[5:0], 2'b00};
  localparam logic [7:0] ADDR_IRQ_CLR = {IDX_IRQ_CLR[5:0], 2'b00};
  localparam logic [7:0] ADDR_HOLE = 8'h3C;

  // ****************************************
  // reset values, masks and field positions
  // ****************************************
  localparam logic [7:0] STS_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [7:0] STS_B_MASK = 8'h0F;
  localparam logic [7:0] STS_P_MASK = 8'hFE;
  localparam int CTRL_GLOBAL = 0;
  localparam int CTRL_TACH1 = 1;
  localparam int CTRL_TACH2 = 2;
  localparam int SRC_N = 19;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- verilog/wake_input_sync.sv
// three-stage synchroniser with agreement filter for wake source pins
`timescale 1ns/1ps
module wake_input_sync #(
  parameter int WIDTH = 19
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] stable
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] hold_ff;

  // three flops; the first is read only by the second
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      hold_ff <= '0;
    end else begin
      meta_ff <= raw;
      sync_ff <= meta_ff;
      hold_ff <= sync_ff;
    end
  end

  // a bit changes only where stages two and three agree
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stable <= '0;
    end else begin
      stable <= (stable & (sync_ff ^ hold_ff)) | (sync_ff & hold_ff);
    end
  end

endmodule

//--- verilog/wake_status_regs.sv
// wake event status register bank with AXI4-Lite access
// Overview of operation
// - status bits latch events whatever the individual or global enables say
// - a wake event from a source sets its status bit to one
// - writing one to a status bit clears it
// - writing zero to a status bit leaves it unchanged
// - status registers reset to zero only on standby power-on reset
// - group b inputs 0..3 sit in bits 0..3 at index 08, rest reserved
// - group a inputs 0..7 sit in bits 0..7 at index 09
// - index 0A: ring2, ring1, keyboard, mouse, key, fan1, fan2 from bit 1
// - index 0B is reserved and always reads zero
// - fan status bit never sets while its pin is a general input
// - switching a fan pin back to general input clears its status bit
// - power event asserts only with status, individual and global enable set
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module wake_status_regs (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] gpin_a,
  input wire logic [3:0] gpin_b,
  input wire logic ring_indicator_first,
  input wire logic ring_indicator_second,
  input wire logic keyboard_wake,
  input wire logic mouse_wake,
  input wire logic specific_key_wake,
  input wire logic fan_speed_input_first,
  input wire logic fan_speed_input_second,
  output logic power_event_out_n,
  output logic irq
);

  // ****************************************
  // declarations
  // ****************************************
  logic [wake_regs_pkg::SRC_N-1:0] src_raw;
  logic [wake_regs_pkg::SRC_N-1:0] src_level;
  logic [7:0] status_b_ff;
  logic [7:0] status_a_ff;
  logic [7:0] status_p_ff;
  logic [7:0] enable_b_ff;
  logic [7:0] enable_a_ff;
  logic [7:0] enable_p_ff;
  logic [2:0] ctrl_ff;
  logic [2:0] irq_sts_ff;
  logic [2:0] irq_en_ff;
  logic [7:0] set_b;
  logic [7:0] set_a;
  logic [7:0] set_p;
  logic [7:0] tach_clr;
  logic [2:0] irq_event;
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb_ff;
  logic wr_fire;
  logic wr_ok;
  logic [7:0] wr_byte;
  logic wr_b;
  logic wr_a;
  logic wr_p;
  logic ar_fire;
  logic [31:0] nxt_rdata;
  logic nxt_rerr;
  logic event_pending;

  // ****************************************
  // wake source capture
  // ****************************************
  assign src_raw = {fan_speed_input_second, fan_speed_input_first,
                    specific_key_wake, mouse_wake, keyboard_wake,
                    ring_indicator_first, ring_indicator_second,
                    gpin_a, gpin_b};

  wake_input_sync #(
    .WIDTH(wake_regs_pkg::SRC_N)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .raw(src_raw),
    .stable(src_level)
  );

  // set terms per register; enables play no part here
  // enables not used
  assign set_b = {4'h0, src_level[3:0]};
  assign set_a = src_level[11:4];
  assign set_p = {src_level[18] & ctrl_ff[wake_regs_pkg::CTRL_TACH2],
                  src_level[17] & ctrl_ff[wake_regs_pkg::CTRL_TACH1],
                  src_level[16:12], 1'b0};
  assign tach_clr = {~ctrl_ff[wake_regs_pkg::CTRL_TACH2],
                     ~ctrl_ff[wake_regs_pkg::CTRL_TACH1], 6'h00};

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_ok = (awaddr_ff[1:0] == 2'b00) && (awaddr_ff <= wake_regs_pkg::ADDR_IRQ_CLR)
                 && (awaddr_ff >= wake_regs_pkg::ADDR_STS_B)
                 && (awaddr_ff != wake_regs_pkg::ADDR_HOLE);
  assign wr_byte = wstrb_ff ? wdata_ff : 8'h00;
  assign wr_b = wr_fire && (awaddr_ff == wake_regs_pkg::ADDR_STS_B);
  assign wr_a = wr_fire && (awaddr_ff == wake_regs_pkg::ADDR_STS_A);
  assign wr_p = wr_fire && (awaddr_ff == wake_regs_pkg::ADDR_STS_P);

  // address and data are held independently, in either order
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wstrb_ff <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // write response once both halves are in
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= wake_regs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? wake_regs_pkg::RESP_OKAY : wake_regs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // wake status registers
  // ****************************************
  // sticky bits, set beats a same-cycle clear, reserved bits masked
  // standby reset only
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_b_ff <= wake_regs_pkg::STS_RST;
      status_a_ff <= wake_regs_pkg::STS_RST;
      status_p_ff <= wake_regs_pkg::STS_RST;
    end else begin
      status_b_ff <= ((status_b_ff & ~(wr_b ? wr_byte : 8'h00)) | set_b)
                     & wake_regs_pkg::STS_B_MASK;
      status_a_ff <= (status_a_ff & ~(wr_a ? wr_byte : 8'h00)) | set_a;
      status_p_ff <= ((status_p_ff & ~(wr_p ? wr_byte : 8'h00) & ~tach_clr) | set_p)
                     & wake_regs_pkg::STS_P_MASK;
    end
  end

  // ****************************************
  // enable, control and interrupt registers
  // ****************************************
  // plain read/write registers, low byte only
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_b_ff <= wake_regs_pkg::EN_RST;
      enable_a_ff <= wake_regs_pkg::EN_RST;
      enable_p_ff <= wake_regs_pkg::EN_RST;
      ctrl_ff <= wake_regs_pkg::CTRL_RST;
      irq_en_ff <= wake_regs_pkg::IRQ_RST;
    end else if (wr_fire && wstrb_ff) begin
      unique case (awaddr_ff)
        wake_regs_pkg::ADDR_EN_B: begin
          enable_b_ff <= wdata_ff & wake_regs_pkg::STS_B_MASK;
        end
        wake_regs_pkg::ADDR_EN_A: begin
          enable_a_ff <= wdata_ff;
        end
        wake_regs_pkg::ADDR_EN_P: begin
          enable_p_ff <= wdata_ff & wake_regs_pkg::STS_P_MASK;
        end
        wake_regs_pkg::ADDR_CTRL: begin
          ctrl_ff <= wdata_ff[2:0];
        end
        wake_regs_pkg::ADDR_IRQ_EN: begin
          irq_en_ff <= wdata_ff[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // a newly set status bit in a register raises its interrupt bit
  assign irq_event = {|(set_p & ~status_p_ff), |(set_a & ~status_a_ff),
                      |(set_b & ~status_b_ff)};

  // sticky interrupt status, set wins over write-one clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_sts_ff <= wake_regs_pkg::IRQ_RST;
    end else if (wr_fire && wstrb_ff && (awaddr_ff == wake_regs_pkg::ADDR_IRQ_CLR)) begin
      irq_sts_ff <= (irq_sts_ff & ~wdata_ff[2:0]) | irq_event;
    end else begin
      irq_sts_ff <= irq_sts_ff | irq_event;
    end
  end

  assign irq = |(irq_sts_ff & irq_en_ff);

  // ****************************************
  // power event output
  // ****************************************
  // three-way gating
  assign event_pending = ctrl_ff[wake_regs_pkg::CTRL_GLOBAL]
                         && |{status_b_ff & enable_b_ff, status_a_ff & enable_a_ff,
                              status_p_ff & enable_p_ff};

  // active low, registered
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_event_out_n <= 1'b1;
    end else begin
      power_event_out_n <= !event_pending;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // read decode; unmapped or misaligned answers SLVERR with zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rerr = 1'b0;
    unique case (s_axi_araddr)
      wake_regs_pkg::ADDR_STS_B: nxt_rdata[7:0] = status_b_ff;
      wake_regs_pkg::ADDR_STS_A: nxt_rdata[7:0] = status_a_ff;
      wake_regs_pkg::ADDR_STS_P: nxt_rdata[7:0] = status_p_ff;
      wake_regs_pkg::ADDR_RSVD: nxt_rdata[7:0] = 8'h00;
      wake_regs_pkg::ADDR_EN_B: nxt_rdata[7:0] = enable_b_ff;
      wake_regs_pkg::ADDR_EN_A: nxt_rdata[7:0] = enable_a_ff;
      wake_regs_pkg::ADDR_EN_P: nxt_rdata[7:0] = enable_p_ff;
      wake_regs_pkg::ADDR_CTRL: nxt_rdata[2:0] = ctrl_ff;
      wake_regs_pkg::ADDR_IRQ_STS: nxt_rdata[2:0] = irq_sts_ff;
      wake_regs_pkg::ADDR_IRQ_EN: nxt_rdata[2:0] = irq_en_ff;
      wake_regs_pkg::ADDR_IRQ_CLR: nxt_rdata[2:0] = 3'h0;
      default: nxt_rerr = 1'b1;
    endcase
  end

  // read data held until rready
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= wake_regs_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= nxt_rdata;
      s_axi_rresp <= nxt_rerr ? wake_regs_pkg::RESP_SLVERR : wake_regs_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence src_a0_held_s;
    gpin_a[0] [*6];
  endsequence

  sequence mode1_low_s;
    !ctrl_ff[wake_regs_pkg::CTRL_TACH1] ##1 !ctrl_ff[wake_regs_pkg::CTRL_TACH1];
  endsequence

  set_on_event_a: assert property ((|set_a) |=> ((status_a_ff & $past(set_a)) == $past(set_a)))
    else $error("status bit not set by event");
  src_to_status_a: assert property (src_a0_held_s |-> status_a_ff[0])
    else $error("held source did not reach status");
  one_clears_a: assert property ((wr_a && wstrb_ff && set_a == 8'h00)
      |=> ((status_a_ff & $past(wdata_ff)) == 8'h00))
    else $error("write one did not clear");
  zero_keeps_a: assert property (wr_a
      |=> (($past(status_a_ff) & ~$past(wr_byte) & ~status_a_ff) == 8'h00))
    else $error("write zero changed a bit");
  sticky_hold_a: assert property (!wr_b |=> (($past(status_b_ff) & ~status_b_ff) == 8'h00))
    else $error("status bit dropped without clear");
  rsvd_bits_a: assert property (status_b_ff[7:4] == 4'h0 && !status_p_ff[0])
    else $error("reserved status bit set");
  rsvd_read_a: assert property ((ar_fire && s_axi_araddr == wake_regs_pkg::ADDR_RSVD)
      |=> (s_axi_rvalid && s_axi_rdata == 32'h0000_0000))
    else $error("reserved offset read nonzero");
  tach_gpio_a: assert property (mode1_low_s |-> !status_p_ff[6])
    else $error("fan status set in gpio mode");
  tach_switch_a: assert property ($fell(ctrl_ff[wake_regs_pkg::CTRL_TACH2])
      |=> !status_p_ff[7])
    else $error("fan status kept after switch");
  power_gate_a: assert property (!ctrl_ff[wake_regs_pkg::CTRL_GLOBAL] [*2]
      |-> power_event_out_n)
    else $error("power event without global enable");
  irq_set_a: assert property ((|irq_event)
      |=> ((irq_sts_ff & $past(irq_event)) == $past(irq_event)))
    else $error("interrupt status not set by event");

endmodule

//--- bench/wake_src_model.sv
// wake event source model: drives level events on the wake pins
`timescale 1ns/1ps
module wake_src_model (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [18:0] pattern,
  input wire logic [7:0] hold_cycles,
  output logic [18:0] level = '0
);
  int cnt = 0;
  // ****************************************
  // event timing
  // ****************************************
  // hold the requested levels for hold_cycles, then fall back to idle low
  always @(posedge ref_clk) begin
    if (go) begin
      level <= pattern;
      cnt <= int'(hold_cycles);
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      level <= '0;
      cnt <= 0;
    end
  end
endmodule

//--- bench/tb_top.sv
// self-checking bench for the wake event status register bank
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 0;
  logic sys_rst = 1;
  logic [7:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 0;
  logic [7:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 0;
  logic ev_go = 0;
  logic [18:0] ev_pat = '0;
  logic [7:0] ev_hold = 8'h0c;
  logic [18:0] ev;
  logic power_event_out_n;
  logic irq;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int sa, sb, sp, ea, eb, ep, ctl, is, ie, k, m; // reference model state
  logic [31:0] rv;
  logic [1:0] rr;

  // ****************************************
  // clock, instances and timeout
  // ****************************************
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  wake_src_model i_wake_src_model (.ref_clk(ref_clk), .go(ev_go), .pattern(ev_pat),
    .hold_cycles(ev_hold), .level(ev));
  wake_status_regs i_wake_status_regs (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .gpin_a(ev[7:0]),
    .gpin_b(ev[11:8]), .ring_indicator_second(ev[12]), .ring_indicator_first(ev[13]),
    .keyboard_wake(ev[14]), .mouse_wake(ev[15]), .specific_key_wake(ev[16]),
    .fan_speed_input_first(ev[17]), .fan_speed_input_second(ev[18]),
    .power_event_out_n(power_event_out_n), .irq(irq));
  // cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // write: both halves offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, b;
    b = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!b) begin
      @(negedge ref_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge ref_clk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    r = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!r) begin
      @(negedge ref_clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge ref_clk);
      if (ar) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input int exp);
    rd(a);
    chk(what, rv, exp);
    chk("read resp", {30'h0, rr}, 32'h0000_0000);
  endtask
  // raise a random-length event burst and update the reference model
  task automatic fire(input logic [18:0] p);
    int np;
    @(posedge ref_clk);
    ev_pat <= p;
    ev_hold <= 8'(10 + $urandom_range(0, 10));
    ev_go <= 1;
    @(posedge ref_clk);
    ev_go <= 0;
    repeat (40) @(posedge ref_clk);
    np = sp | (int'({p[18:12], 1'b0}) & int'({ctl[2], ctl[1], 6'h3f}));
    is |= ((int'(p[11:8]) & ~sb) != 0) | (((int'(p[7:0]) & ~sa) != 0) << 1);
    is |= ((np & ~sp) != 0) << 2;
    sa |= int'(p[7:0]);
    sb |= int'(p[11:8]);
    sp = np;
  endtask
  task automatic check_all();
    rchk("group a", wake_regs_pkg::ADDR_STS_A, sa);
    rchk("group b", wake_regs_pkg::ADDR_STS_B, sb);
    rchk("peripherals", wake_regs_pkg::ADDR_STS_P, sp);
    rchk("reserved", wake_regs_pkg::ADDR_RSVD, 0);
    rchk("irq status", wake_regs_pkg::ADDR_IRQ_STS, is);
    @(negedge ref_clk);
    m = ctl[0] && (((sa & ea) | (sb & eb) | (sp & ep)) != 0);
    chk("power event", power_event_out_n, !m);
    chk("irq", irq, (is & ie) != 0);
  endtask
  task automatic model_clear();
    {sa, sb, sp, ea, eb, ep, ctl, is, ie} = '0;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h6550));
    model_clear();
    repeat (2) @(posedge ref_clk);
    sys_rst <= 0;
    check_all();
    rd(8'h3c);
    chk("unmapped resp", rr, wake_regs_pkg::RESP_SLVERR);
    // events with every enable off, fans in general input mode
    for (k = 0; k < 3; k++) begin
      fire(19'($urandom));
      check_all();
    end
    // fans in tach mode, then back to general input
    wr(wake_regs_pkg::ADDR_IRQ_EN, 8'h07);
    ie = 7;
    wr(wake_regs_pkg::ADDR_CTRL, 8'h06);
    ctl = 6;
    fire(19'h6_0000 | 19'($urandom));
    check_all();
    wr(wake_regs_pkg::ADDR_CTRL, 8'h00);
    ctl = 0;
    sp &= 'h3f;
    check_all();
    // write one clears, write zero keeps, reserved bits ignore writes
    for (k = 0; k < 3; k++) begin
      m = $urandom_range(0, 255);
      wr(wake_regs_pkg::ADDR_STS_A, 8'(m));
      sa &= ~m;
      wr(wake_regs_pkg::ADDR_STS_B, 8'hff);
      sb = 0;
      wr(wake_regs_pkg::ADDR_STS_P, 8'(m));
      sp &= ~m;
      check_all();
      fire(19'($urandom));
    end
    // a write with no byte strobe changes nothing
    @(posedge ref_clk);
    s_axi_wstrb <= 4'h0;
    wr(wake_regs_pkg::ADDR_STS_A, 8'hff);
    s_axi_wstrb <= 4'hf;
    wr(wake_regs_pkg::ADDR_RSVD, 8'hff);
    chk("reserved write resp", rr, wake_regs_pkg::RESP_OKAY);
    check_all();
    // power event needs status, source enable and global enable
    wr(wake_regs_pkg::ADDR_CTRL, 8'h01);
    ctl = 1;
    check_all();
    wr(wake_regs_pkg::ADDR_EN_A, 8'hff);
    ea = 255;
    wr(wake_regs_pkg::ADDR_EN_P, 8'hff);
    ep = 'hfe;
    fire(19'($urandom) | 19'h0_0001);
    check_all();
    wr(wake_regs_pkg::ADDR_IRQ_CLR, 8'h07);
    is = 0;
    wr(wake_regs_pkg::ADDR_STS_A, 8'hff);
    sa = 0;
    wr(wake_regs_pkg::ADDR_STS_P, 8'hff);
    sp = 0;
    check_all();
    fire(19'h0_0f00);
    check_all();
    // reset in mid run clears every status bit
    @(posedge ref_clk);
    sys_rst <= 1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 0;
    model_clear();
    check_all();
    finish_test();
  end
endmodule
